// File: src/irq_bank_defs.svh
// Purpose: offsets, field positions, reset values and counts of the flag/enable bank
// Assumes: 32-bit classic Wishbone words, registers on aligned byte addresses
// Notes:   one slot = one request source; four slots share one byte register
`ifndef IRQ_BANK_DEFS_SVH
`define IRQ_BANK_DEFS_SVH

// register byte offsets
`define OFS_IRQ_CTRL_SECOND   8'h00
`define OFS_IRQ_CTRL_THIRD    8'h04
`define OFS_MULTIFUNC_GROUP_A 8'h08
`define OFS_MULTIFUNC_GROUP_B 8'h0C
`define OFS_MULTIFUNC_GROUP_C 8'h10
`define OFS_CORE_CTRL         8'h14
`define OFS_EVT_STATUS        8'h18
`define OFS_EVT_MASK          8'h1C
`define OFS_VEC_STATE         8'h20

// slot layout: four slots per byte register, flags high nibble, enables low
`define SLOT_COUNT            20
`define SLOTS_PER_REG         4
`define FLAG_BIT_TOP          7
`define EN_BIT_TOP            3
`define SLOT_IMPL_MASK        20'hC_FFCF

// slot numbers of the sources
`define SLOT_SERIAL0          0
`define SLOT_SERIAL_IFACE     1
`define SLOT_EXT_PIN1         2
`define SLOT_TICK1            3
`define SLOT_EXT_PIN2         6
`define SLOT_SERIAL1          7

// vector outputs
`define VEC_COUNT             6
`define GROUP_COUNT           3
`define GROUP_A_BASE          8
`define GROUP_B_BASE          12
`define GROUP_C_BASE          16

// core control field and reset values
`define CORE_GIE_BIT          0
`define RST_BYTE_REG          8'h00
`define RST_SLOTS             20'h0_0000
`define RST_WORD              32'h0000_0000

`endif

// File: src/irq_bank_pkg.sv
// Purpose: types shared by the flag/enable bank files
// Assumes: constants live in irq_bank_defs.svh
// Notes:   register select is a plain enumeration decoded from the address
package irq_bank_pkg;

    typedef logic [7:0] byte_reg_t;

    typedef enum logic [3:0] {
        SEL_CTRL_SECOND,
        SEL_CTRL_THIRD,
        SEL_GROUP_A,
        SEL_GROUP_B,
        SEL_GROUP_C,
        SEL_CORE,
        SEL_EVT_STATUS,
        SEL_EVT_MASK,
        SEL_VEC_STATE,
        SEL_NONE
    } reg_sel_t;

endpackage : irq_bank_pkg

// File: src/req_flag_cell.sv
// Purpose: one request flag with event set, software write and service clear
// Assumes: event, write and clear are single-cycle strobes on clk_i
// Notes:   a set always beats a clear in the same cycle
`timescale 1ns/1ps
module req_flag_cell (
    // clock and reset
    input  wire logic clk_i,
    input  wire logic rst_i,
    input  wire logic ce_i,
    // set, write and clear
    input  wire logic event_i,
    input  wire logic wr_i,
    input  wire logic wr_bit_i,
    input  wire logic hw_clr_i,
    // state
    output logic      flag_o
);

    logic flag_ff;

    // flag update, event has precedence over any clear
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            flag_ff <= 1'b0;
        end else if (ce_i) begin
            if (event_i) begin
                flag_ff <= 1'b1;
            end else if (wr_i) begin
                flag_ff <= wr_bit_i;
            end else if (hw_clr_i) begin
                flag_ff <= 1'b0;
            end
        end
    end

    assign flag_o = flag_ff;

endmodule : req_flag_cell

// File: src/irq_flag_enable_bank.sv
// Purpose: five byte registers of interrupt request flags and enables
// Assumes: peripheral events are one-cycle pulses on clk_i, no resync needed
// Notes:   Wishbone classic slave, ack one cycle after the request is seen
`timescale 1ns/1ps
`include "irq_bank_defs.svh"
module irq_flag_enable_bank
    import irq_bank_pkg::*;
#(
    parameter int ADDR_W = 8
) (
    // clock, reset and clock enable
    input  wire logic                     clk_i,
    input  wire logic                     rst_i,
    input  wire logic                     ce_i,
    // wishbone classic slave
    input  wire logic                     cyc_i,
    input  wire logic                     stb_i,
    input  wire logic                     we_i,
    input  wire logic [ADDR_W-1:0]        adr_i,
    input  wire logic [3:0]               sel_i,
    input  wire logic [31:0]              dat_i,
    output logic      [31:0]              dat_o,
    output logic                          ack_o,
    // peripheral events, one pulse per slot
    input  wire logic [`SLOT_COUNT-1:0]   src_event_i,
    // cpu sequencer service strobe
    input  wire logic                     svc_ack_i,
    input  wire logic [2:0]               svc_vec_i,
    // requests towards the sequencer
    output logic [`VEC_COUNT-1:0]         vec_req_o,
    output logic [`GROUP_COUNT-1:0]       mf_req_o,
    output logic                          global_irq_enable_o,
    output logic                          wake_o,
    output logic                          irq_o
);

    // slot count and implemented-slot mask
    localparam int                      NSLOT = `SLOT_COUNT;
    localparam logic [`SLOT_COUNT-1:0]  IMPL  = `SLOT_IMPL_MASK;

    // elaboration check on address width
    if (ADDR_W < 6) begin : g_bad_addr
        $error("ADDR_W too small for the register map");
    end

    // slot map must tile the five byte registers exactly
    if (NSLOT != 5 * `SLOTS_PER_REG) begin : g_bad_slots
        $error("slot count does not match the register map");
    end

    // vector state image packs six direct requests and three groups
    if (`VEC_COUNT != 6 || `GROUP_COUNT != 3) begin : g_bad_vec
        $error("vector counts do not match the state register");
    end

    // address decode, used for read and write paths
    function automatic reg_sel_t decode(input logic [ADDR_W-1:0] a);
        logic [7:0] ofs;
        ofs = 8'(a);
        if (ADDR_W > 8 && (a >> 8) != '0) begin
            return SEL_NONE;
        end
        case (ofs)
            `OFS_IRQ_CTRL_SECOND:   return SEL_CTRL_SECOND;
            `OFS_IRQ_CTRL_THIRD:    return SEL_CTRL_THIRD;
            `OFS_MULTIFUNC_GROUP_A: return SEL_GROUP_A;
            `OFS_MULTIFUNC_GROUP_B: return SEL_GROUP_B;
            `OFS_MULTIFUNC_GROUP_C: return SEL_GROUP_C;
            `OFS_CORE_CTRL:         return SEL_CORE;
            `OFS_EVT_STATUS:        return SEL_EVT_STATUS;
            `OFS_EVT_MASK:          return SEL_EVT_MASK;
            `OFS_VEC_STATE:         return SEL_VEC_STATE;
            default:                return SEL_NONE;
        endcase
    endfunction : decode

    // byte-lane mask from the select lines
    function automatic logic [31:0] lane_mask(input logic [3:0] s);
        return {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
    endfunction : lane_mask

    // direct vector number to its slot
    function automatic int vec_slot(input int v);
        case (v)
            0:       return `SLOT_SERIAL0;
            1:       return `SLOT_SERIAL_IFACE;
            2:       return `SLOT_EXT_PIN1;
            3:       return `SLOT_TICK1;
            4:       return `SLOT_EXT_PIN2;
            default: return `SLOT_SERIAL1;
        endcase
    endfunction : vec_slot

    // bus side state
    logic                 ack_ff;
    logic [31:0]          dat_ff;

    // slot storage
    logic [NSLOT-1:0]     flag;
    logic [NSLOT-1:0]     enable_ff;
    logic [NSLOT-1:0]     evt_stat_ff;
    logic [NSLOT-1:0]     evt_mask_ff;
    logic                 gie_ff;

    // registered outputs
    logic [`VEC_COUNT-1:0]   vec_req_ff;
    logic [`GROUP_COUNT-1:0] mf_req_ff;
    logic                 wake_ff;
    logic                 irq_ff;

    // per-slot steering
    logic [NSLOT-1:0]     slot_wr;
    logic [NSLOT-1:0]     slot_flag_wd;
    logic [NSLOT-1:0]     slot_en_wd;
    logic [NSLOT-1:0]     slot_svc_clr;
    logic [NSLOT-1:0]     slot_event;

    // next values
    logic [NSLOT-1:0]     nxt_enable;
    logic [NSLOT-1:0]     nxt_evt_stat;
    logic [NSLOT-1:0]     nxt_evt_mask;
    logic [`VEC_COUNT-1:0]   nxt_vec_req;
    logic [`GROUP_COUNT-1:0] nxt_mf_req;
    logic [31:0]          nxt_dat;

    // bus decode
    logic [31:0]          wmask;
    reg_sel_t             sel;
    logic                 req_seen;
    logic                 wr_fire;
    logic                 byte_reg_wr;

    // bus request qualification
    assign sel         = decode(adr_i);
    assign req_seen    = cyc_i & stb_i & ~ack_ff;
    assign wr_fire     = cyc_i & stb_i & we_i & ack_ff & ce_i;
    assign wmask       = lane_mask(sel_i);
    assign byte_reg_wr = wr_fire & sel_i[0] & (sel <= SEL_GROUP_C);
    assign slot_event  = src_event_i & IMPL;

    // per-slot write steering and flag storage
    genvar g;
    for (g = 0; g < NSLOT; g++) begin : g_slot
        localparam int REG = g / `SLOTS_PER_REG;
        localparam int POS = g % `SLOTS_PER_REG;

        // write strobe and data bits of this slot
        assign slot_wr[g]      = byte_reg_wr & (sel == reg_sel_t'(REG));
        assign slot_flag_wd[g] = dat_i[`FLAG_BIT_TOP - POS];
        assign slot_en_wd[g]   = dat_i[`EN_BIT_TOP - POS];

        if (IMPL[g]) begin : g_cell
            req_flag_cell u_flag (
                .clk_i    (clk_i),
                .rst_i    (rst_i),
                .ce_i     (ce_i),
                .event_i  (slot_event[g]),
                .wr_i     (slot_wr[g]),
                .wr_bit_i (slot_flag_wd[g]),
                .hw_clr_i (slot_svc_clr[g]),
                .flag_o   (flag[g])
            );
        end else begin : g_none
            assign flag[g] = 1'b0;
        end
    end

    // service strobe clears the flag of the vector being entered
    always_comb begin
        slot_svc_clr = '0;
        for (int v = 0; v < `VEC_COUNT; v++) begin
            if (svc_ack_i && int'(svc_vec_i) == v) begin
                slot_svc_clr[vec_slot(v)] = 1'b1;
            end
        end
    end

    // enable bits, only implemented positions can hold a one
    always_comb begin
        nxt_enable = enable_ff;
        for (int i = 0; i < NSLOT; i++) begin
            if (slot_wr[i]) begin
                nxt_enable[i] = slot_en_wd[i] & IMPL[i];
            end
        end
    end

    // enable storage, frozen while ce_i is low
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            enable_ff <= `RST_SLOTS;
        end else if (ce_i) begin
            enable_ff <= nxt_enable;
        end
    end

    // global enable, service entry clears it
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            gie_ff <= 1'b0;
        end else if (ce_i) begin
            if (svc_ack_i) begin
                gie_ff <= 1'b0;
            end else if (wr_fire && sel == SEL_CORE && sel_i[0]) begin
                gie_ff <= dat_i[`CORE_GIE_BIT];
            end
        end
    end

    // sticky event status, write one to clear, set wins
    always_comb begin
        nxt_evt_stat = evt_stat_ff;
        if (wr_fire && sel == SEL_EVT_STATUS) begin
            nxt_evt_stat = evt_stat_ff & ~(dat_i[NSLOT-1:0] & wmask[NSLOT-1:0]);
        end
        nxt_evt_stat = nxt_evt_stat | slot_event;
    end

    // event mask with byte lanes
    always_comb begin
        nxt_evt_mask = evt_mask_ff;
        if (wr_fire && sel == SEL_EVT_MASK) begin
            nxt_evt_mask = ((evt_mask_ff & ~wmask[NSLOT-1:0])
                         | (dat_i[NSLOT-1:0] & wmask[NSLOT-1:0])) & IMPL;
        end
    end

    // status and mask storage
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            evt_stat_ff <= `RST_SLOTS;
            evt_mask_ff <= `RST_SLOTS;
        end else if (ce_i) begin
            evt_stat_ff <= nxt_evt_stat;
            evt_mask_ff <= nxt_evt_mask;
        end
    end

    // direct vector requests and group requests
    always_comb begin
        nxt_vec_req = '0;
        nxt_mf_req  = '0;
        for (int v = 0; v < `VEC_COUNT; v++) begin
            nxt_vec_req[v] = flag[vec_slot(v)] & enable_ff[vec_slot(v)] & gie_ff;
        end
        for (int k = 0; k < `SLOTS_PER_REG; k++) begin
            nxt_mf_req[0] = nxt_mf_req[0]
                          | (flag[`GROUP_A_BASE + k] & enable_ff[`GROUP_A_BASE + k]);
            nxt_mf_req[1] = nxt_mf_req[1]
                          | (flag[`GROUP_B_BASE + k] & enable_ff[`GROUP_B_BASE + k]);
            nxt_mf_req[2] = nxt_mf_req[2]
                          | (flag[`GROUP_C_BASE + k] & enable_ff[`GROUP_C_BASE + k]);
        end
    end

    // registered request, wake and interrupt outputs
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            vec_req_ff <= '0;
            mf_req_ff  <= '0;
            wake_ff    <= 1'b0;
            irq_ff     <= 1'b0;
        end else if (ce_i) begin
            vec_req_ff <= nxt_vec_req;
            mf_req_ff  <= nxt_mf_req;
            wake_ff    <= |flag;
            irq_ff     <= |(evt_stat_ff & evt_mask_ff);
        end
    end

    // one byte register image from the slot vectors
    function automatic byte_reg_t pack_reg(input int r,
                                           input logic [NSLOT-1:0] f,
                                           input logic [NSLOT-1:0] e);
        byte_reg_t b;
        b = `RST_BYTE_REG;
        for (int k = 0; k < `SLOTS_PER_REG; k++) begin
            b[`FLAG_BIT_TOP - k] = f[r * `SLOTS_PER_REG + k];
            b[`EN_BIT_TOP - k]   = e[r * `SLOTS_PER_REG + k];
        end
        return b;
    endfunction : pack_reg

    // read data mux, unmapped reads return zero
    always_comb begin
        nxt_dat = `RST_WORD;
        case (sel)
            SEL_CTRL_SECOND: nxt_dat[7:0] = pack_reg(0, flag, enable_ff);
            SEL_CTRL_THIRD:  nxt_dat[7:0] = pack_reg(1, flag, enable_ff);
            SEL_GROUP_A:     nxt_dat[7:0] = pack_reg(2, flag, enable_ff);
            SEL_GROUP_B:     nxt_dat[7:0] = pack_reg(3, flag, enable_ff);
            SEL_GROUP_C:     nxt_dat[7:0] = pack_reg(4, flag, enable_ff);
            SEL_CORE:        nxt_dat[`CORE_GIE_BIT] = gie_ff;
            SEL_EVT_STATUS:  nxt_dat[NSLOT-1:0] = evt_stat_ff;
            SEL_EVT_MASK:    nxt_dat[NSLOT-1:0] = evt_mask_ff;
            SEL_VEC_STATE:   nxt_dat[15:0] = {5'(0), mf_req_ff, 2'(0), vec_req_ff};
            default:         nxt_dat = `RST_WORD;
        endcase
    end

    // ack one cycle after the request, dropped the cycle after
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_ff <= 1'b0;
            dat_ff <= `RST_WORD;
        end else if (ce_i) begin
            ack_ff <= req_seen;
            if (req_seen) begin
                dat_ff <= we_i ? `RST_WORD : nxt_dat;
            end
        end
    end

    // ports straight from the flops
    assign dat_o               = dat_ff;
    assign ack_o               = ack_ff;
    assign vec_req_o           = vec_req_ff;
    assign mf_req_o            = mf_req_ff;
    assign global_irq_enable_o = gie_ff;
    assign wake_o              = wake_ff;
    assign irq_o               = irq_ff;

endmodule : irq_flag_enable_bank

// File: tb/irq_flag_enable_bank_properties.sv
// Purpose: port-level properties of the flag/enable bank
// Assumes: ce_i held high by the bench
// Notes:   sees only the top module's ports
`timescale 1ns/1ps
module irq_bank_checker #(
    parameter int ADDR_W = 8
) (
    // clock and reset
    input wire logic              clk_i,
    input wire logic              rst_i,
    input wire logic              ce_i,
    // bus
    input wire logic              cyc_i,
    input wire logic              stb_i,
    input wire logic              we_i,
    input wire logic [ADDR_W-1:0] adr_i,
    input wire logic [3:0]        sel_i,
    input wire logic [31:0]       dat_i,
    input wire logic [31:0]       dat_o,
    input wire logic              ack_o,
    // events and service
    input wire logic [19:0]       src_event_i,
    input wire logic              svc_ack_i,
    input wire logic [2:0]        svc_vec_i,
    // requests
    input wire logic [5:0]        vec_req_o,
    input wire logic [2:0]        mf_req_o,
    input wire logic              global_irq_enable_o,
    input wire logic              wake_o,
    input wire logic              irq_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    // bus handshake
    a_ack_answer: assert property (cyc_i && stb_i && !ack_o && ce_i |=> ack_o)
        else $error("no ack after request");
    a_ack_single: assert property (ack_o |=> !ack_o)
        else $error("ack longer than one cycle");
    a_write_reads_zero: assert property (ack_o && $past(we_i) |-> dat_o == 32'h0000_0000)
        else $error("read data during write ack");
    // state after reset
    a_reset_quiet: assert property ($past(rst_i) |-> vec_req_o == 6'h00 && !wake_o
        && !global_irq_enable_o && mf_req_o == 3'h0 && !irq_o)
        else $error("outputs not clear after reset");
    // events, gating and service
    a_event_wakes: assert property ((src_event_i & 20'hC_FFCF) != 20'h0_0000 |-> ##2 wake_o)
        else $error("event did not wake");
    a_vec_needs_gie: assert property (vec_req_o != 6'h00 |-> $past(global_irq_enable_o))
        else $error("request without global enable");
    a_svc_blocks: assert property (svc_ack_i |=> !global_irq_enable_o ##1 vec_req_o == 6'h00)
        else $error("service did not block requests");
    a_group_flagged: assert property (mf_req_o != 3'h0 |-> wake_o)
        else $error("group request without flag");
    a_vec_flagged: assert property (vec_req_o != 6'h00 |-> wake_o)
        else $error("vector request without flag");

    c_service: cover property (svc_ack_i);
    c_irq: cover property (irq_o);
    c_group: cover property (mf_req_o[0]);
endmodule : irq_bank_checker

// File: tb/irq_seq_model.sv
// Purpose: behavioural cpu sequencer answering vector requests
// Assumes: bench arms it and chooses the reply delay
// Notes:   select toggles while no service strobe is given
`timescale 1ns/1ps
module irq_seq_model (
    // clock and reset
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    // bench control
    input  wire logic       arm_i,
    input  wire logic [3:0] delay_i,
    // bank side
    input  wire logic [5:0] vec_req_i,
    output logic            svc_ack_o,
    output logic [2:0]      svc_vec_o
);
    logic [3:0] wait_ff;
    logic       busy_ff;
    logic [2:0] pick;

    // lowest numbered request wins
    always_comb begin
        pick = 3'h0;
        for (int k = 5; k >= 0; k--)
            if (vec_req_i[k]) pick = 3'(k);
    end

    // wait, strobe once, then hold off until requests fall
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wait_ff   <= 4'h0;
            busy_ff   <= 1'b0;
            svc_ack_o <= 1'b0;
            svc_vec_o <= 3'h0;
        end else if (busy_ff) begin
            svc_ack_o <= 1'b0;
            svc_vec_o <= ~svc_vec_o;
            busy_ff   <= (vec_req_i != 6'h00);
        end else if (arm_i && vec_req_i != 6'h00 && wait_ff == delay_i) begin
            svc_ack_o <= 1'b1;
            svc_vec_o <= pick;
            busy_ff   <= 1'b1;
            wait_ff   <= 4'h0;
        end else begin
            svc_ack_o <= 1'b0;
            svc_vec_o <= ~svc_vec_o;
            if (arm_i && vec_req_i != 6'h00) wait_ff <= wait_ff + 4'h1;
        end
    end
endmodule : irq_seq_model

// File: tb/tb_irq_flag_enable_bank.sv
// Purpose: register, event and service sequences for the flag/enable bank
// Assumes: ce_i and sel_i held on, sequencer model answers service
// Notes:   expected values come from the full register table below and the slot mask
`timescale 1ns/1ps
module tb_irq_flag_enable_bank;
    import irq_bank_pkg::*;
    localparam int ADDR_W = 8;
    logic clk_i, rst_i, ce_i, cyc_i, stb_i, we_i, ack_o, svc_ack_i, arm, wake_o, irq_o;
    logic global_irq_enable_o;
    logic [ADDR_W-1:0] adr_i;
    logic [3:0]  sel_i, dly;
    logic [31:0] dat_i, dat_o, q;
    logic [19:0] src_event_i;
    logic [2:0]  svc_vec_i, mf_req_o;
    logic [5:0]  vec_req_o;
    int checks, miscompares;
    byte_reg_t full [5] = '{8'hFF, 8'h33, 8'hFF, 8'hFF, 8'h33};

    irq_flag_enable_bank #(.ADDR_W(ADDR_W)) i_irq_flag_enable_bank (.*);
    irq_seq_model i_irq_seq_model (.clk_i(clk_i), .rst_i(rst_i), .arm_i(arm),
        .delay_i(dly), .vec_req_i(vec_req_o), .svc_ack_o(svc_ack_i), .svc_vec_o(svc_vec_i));

    // clock generator
    initial begin
        clk_i = 1'b0;
        forever #20 clk_i = ~clk_i;
    end

    task automatic finish_test();
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : finish_test

    task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected at %0t: register %h, expected %h", $time, got, exp);
        end
    endtask : chk_reg

    task automatic chk_pin(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected at %0t: output %h, expected %h", $time, got, exp);
        end
    endtask : chk_pin

    // one classic cycle, entered just after a rising edge
    task automatic wb_go(input logic w, input logic [7:0] a, input logic [31:0] d);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        sel_i <= 4'hF;
        we_i  <= w;
        adr_i <= a;
        dat_i <= d;
        @(posedge clk_i);
        while (ack_o !== 1'b1) @(posedge clk_i);
        q = dat_o;
        src_event_i <= 20'h0_0000; // an event staged by the caller ends with the transfer
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        @(posedge clk_i);
    endtask : wb_go

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        wb_go(1'b0, a, 32'h0000_0000);
        chk_reg(q, exp);
    endtask : rd_chk

    task automatic pulse(input logic [19:0] m);
        src_event_i <= m;
        @(posedge clk_i);
        src_event_i <= 20'h0_0000;
        @(posedge clk_i);
    endtask : pulse

    // watchdog
    initial begin
        #200000;
        miscompares++;
        finish_test();
    end

    // main sequence
    initial begin
        {rst_i, ce_i, cyc_i, stb_i, we_i, arm} = 6'b110000;
        adr_i = 8'h00;
        sel_i = 4'hF;
        dat_i = 32'h0000_0000;
        src_event_i = 20'h0_0000;
        dly = 4'h3;
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        for (int k = 0; k < 6; k++) rd_chk(8'(4 * k), 32'h0000_0000);
        for (int k = 0; k < 5; k++) begin
            wb_go(1'b1, 8'(4 * k), 32'h0000_00FF);
            rd_chk(8'(4 * k), {24'h00_0000, full[k]});
            wb_go(1'b1, 8'(4 * k), 32'h0000_0000);
        end
        pulse(20'hC_FFCF);
        for (int k = 0; k < 5; k++)
            rd_chk(8'(4 * k), {24'h00_0000, full[k][7:4], 4'h0});
        chk_pin(8'(wake_o), 8'h01);
        chk_pin(8'(vec_req_o), 8'h00);
        // event status, mask and level interrupt
        rd_chk(8'h18, 32'h000C_FFCF);
        chk_pin(8'(irq_o), 8'h00);
        wb_go(1'b1, 8'h1C, 32'h0000_0001);
        @(posedge clk_i);
        chk_pin(8'(irq_o), 8'h01);
        rd_chk(8'h1C, 32'h0000_0001);
        wb_go(1'b1, 8'h18, 32'h000F_FFFF);
        @(posedge clk_i);
        chk_pin(8'(irq_o), 8'h00);
        // enables, global enable, service
        wb_go(1'b1, 8'h00, 32'h0000_00FF);
        @(posedge clk_i);
        chk_pin(8'(vec_req_o), 8'h00);
        wb_go(1'b1, 8'h14, 32'h0000_0001);
        @(posedge clk_i);
        chk_pin(8'(vec_req_o), 8'h0F);
        rd_chk(8'h14, 32'h0000_0001);
        arm <= 1'b1;
        while (svc_ack_i !== 1'b1) @(posedge clk_i);
        arm <= 1'b0;
        repeat (3) @(posedge clk_i);
        chk_pin(8'(global_irq_enable_o), 8'h00);
        chk_pin(8'(vec_req_o), 8'h00);
        rd_chk(8'h00, 32'h0000_007F);
        pulse(20'h0_0001);
        rd_chk(8'h00, 32'h0000_00FF);
        // group requests without global enable
        wb_go(1'b1, 8'h08, 32'h0000_00F8);
        wb_go(1'b1, 8'h10, 32'h0000_0031);
        @(posedge clk_i);
        chk_pin(8'(mf_req_o), 8'h05);
        rd_chk(8'h20, 32'h0000_0500);
        // set wins over a same-cycle software clear
        src_event_i <= 20'h0_0001;
        wb_go(1'b1, 8'h00, 32'h0000_0000);
        @(posedge clk_i);
        rd_chk(8'h00, 32'h0000_0080);
        // unmapped address
        wb_go(1'b1, 8'h24, 32'h0000_00FF);
        rd_chk(8'h24, 32'h0000_0000);
        finish_test();
    end
endmodule : tb_irq_flag_enable_bank

bind irq_flag_enable_bank irq_bank_checker #(.ADDR_W(ADDR_W)) i_irq_bank_checker (.*);
